// ### hw/amw_async_read.sv
`timescale 1ns/1ps
`default_nettype none
`include "amw_map.svh"
module amw_async_read
  import amw_pkg::*;
#(
  parameter int NUM_CS = 4
) (
  input wire logic clk_sys_i,                    // system clock
  input wire logic reset_i,                      // async reset, high
  input wire logic req_i,                        // one-cycle access request
  input wire logic [1:0] req_target_i,           // async, sdram or register space
  input wire logic [`AMW_CS_W-1:0] req_cs_i,     // async chip select
  input wire logic [`AMW_ADDR_W-1:0] req_addr_i, // access address
  input wire logic [NUM_CS-1:0] ext_wait_en_i,   // extended wait per chip select
  input wire logic [`AMW_CNT_W-1:0] max_wait_i,  // extended wait cycle limit
  input wire logic [`AMW_DATA_W-1:0] sdram_rdata_i, // sdram read data, same domain
  input wire logic sdram_done_i,                 // sdram access finished
  input wire logic [`AMW_DATA_W-1:0] reg_rdata_i,   // register space data
  input wire logic [`AMW_DATA_W-1:0] mem_d_i,    // async data pins
  input wire logic mem_wait_i,                   // wait pin, active high
  output logic busy_o,                           // access in progress
  output logic ack_o,                            // one-cycle completion
  output logic [`AMW_DATA_W-1:0] rdata_o,        // read data
  output logic timeout_o,                        // held time-out error
  output logic sdram_req_o,                      // sdram access start pulse
  output logic mem_cs_n_o,                       // async chip select, low
  output logic [`AMW_CS_W-1:0] mem_cs_sel_o,     // selected chip select
  output logic mem_oe_n_o,                       // async output enable, low
  output logic [`AMW_ADDR_W-1:0] mem_a_o         // async address
);
  amw_wait_if wif ();
  amw_wait_cnt u_cnt (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ctl(wif.cnt)
  );

  // pin synchronisers; stage one feeds stage two only
  logic wait_s1, wait_s2;
  logic [`AMW_DATA_W-1:0] d_s1, d_s2;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
      d_s1 <= '0;
      d_s2 <= '0;
    end else begin
      wait_s1 <= mem_wait_i;
      wait_s2 <= wait_s1;
      d_s1 <= mem_d_i;
      d_s2 <= d_s1;
    end
  end

  amw_state_t state, next_state;
  amw_target_t tgt, next_tgt;
  logic [`AMW_CS_W-1:0] cs, next_cs;
  logic ext_mode, next_ext_mode;
  logic [`AMW_CNT_W-1:0] tick, next_tick;
  logic [`AMW_ADDR_W-1:0] addr, next_addr;
  logic busy, next_busy;
  logic ack, next_ack;
  logic [`AMW_DATA_W-1:0] rdata, next_rdata;
  logic timeout, next_timeout;
  logic sreq, next_sreq;
  logic cs_n, next_cs_n;
  logic oe_n, next_oe_n;

  always_comb begin
    next_state = state;
    next_tgt = tgt;
    next_cs = cs;
    next_ext_mode = ext_mode;
    next_tick = tick;
    next_addr = addr;
    next_busy = busy;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_timeout = timeout;
    next_sreq = 1'b0;
    next_cs_n = cs_n;
    next_oe_n = oe_n;
    wif.start = 1'b0;
    wif.count_en = 1'b0;
    wif.limit = max_wait_i;
    unique case (state)
      AMW_IDLE: begin
        if (req_i) begin
          next_tgt = amw_target_t'(req_target_i);
          next_cs = req_cs_i;
          next_addr = req_addr_i;
          next_busy = 1'b1;
          next_ext_mode = ext_wait_en_i[req_cs_i];
          wif.start = 1'b1;
          next_tick = '0;
          if (req_target_i == AMW_TGT_SDRAM) begin
            next_sreq = 1'b1;
            next_state = AMW_WAIT;
          end else if (req_target_i == AMW_TGT_REGS) begin
            next_state = AMW_DONE;
          end else begin
            next_cs_n = 1'b0;
            next_state = AMW_SETUP;
          end
        end
      end
      AMW_SETUP: begin
        next_tick = tick + `AMW_ONE_CNT;
        if (tick + `AMW_ONE_CNT >= `AMW_SETUP_CYC) begin
          next_tick = '0;
          next_oe_n = 1'b0;
          next_state = AMW_STROBE;
        end
      end
      AMW_STROBE: begin
        // strobe floor covers the two-stage wait sync delay
        next_tick = tick + `AMW_ONE_CNT;
        if (tick + `AMW_ONE_CNT >= `AMW_STROBE_CYC) begin
          next_state = AMW_WAIT;
        end
      end
      AMW_WAIT: begin
        if (tgt == AMW_TGT_SDRAM) begin
          if (sdram_done_i) begin
            next_rdata = sdram_rdata_i;
            next_timeout = 1'b0;
            next_state = AMW_DONE;
          end
        end else if (wif.expired) begin
          next_rdata = `AMW_ZERO_DATA;
          next_timeout = 1'b1;
          next_cs_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = AMW_DONE;
        end else if (ext_mode && wait_s2) begin
          wif.count_en = 1'b1;
        end else begin
          next_rdata = d_s2;
          next_timeout = 1'b0;
          next_cs_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = AMW_DONE;
        end
      end
      AMW_DONE: begin
        if (tgt == AMW_TGT_REGS) begin
          next_rdata = reg_rdata_i;
        end
        next_ack = 1'b1;
        next_busy = 1'b0;
        next_state = AMW_IDLE;
      end
      default: begin
        next_state = AMW_IDLE;
        next_busy = 1'b0;
        next_cs_n = 1'b1;
        next_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= AMW_IDLE;
      tgt <= AMW_TGT_ASYNC;
      cs <= '0;
      ext_mode <= 1'b0;
      tick <= '0;
      addr <= '0;
      busy <= 1'b0;
      ack <= 1'b0;
      rdata <= '0;
      timeout <= 1'b0;
      sreq <= 1'b0;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      cs <= next_cs;
      ext_mode <= next_ext_mode;
      tick <= next_tick;
      addr <= next_addr;
      busy <= next_busy;
      ack <= next_ack;
      rdata <= next_rdata;
      timeout <= next_timeout;
      sreq <= next_sreq;
      cs_n <= next_cs_n;
      oe_n <= next_oe_n;
    end
  end

  assign busy_o = busy;
  assign ack_o = ack;
  assign rdata_o = rdata;
  assign timeout_o = timeout;
  assign sdram_req_o = sreq;
  assign mem_cs_n_o = cs_n;
  assign mem_cs_sel_o = cs;
  assign mem_oe_n_o = oe_n;
  assign mem_a_o = addr;
endmodule : amw_async_read
`default_nettype wire

// ### hw/amw_map.svh
`ifndef AMW_MAP_SVH
`define AMW_MAP_SVH
// widths
`define AMW_DATA_W 32
`define AMW_ADDR_W 24
`define AMW_CS_W 2
`define AMW_CNT_W 8
// access timing and fixed values
`define AMW_SETUP_CYC 8'h02
`define AMW_STROBE_CYC 8'h04
`define AMW_ZERO_DATA 32'h0000_0000
`define AMW_ONE_CNT 8'h01
`endif

// ### hw/amw_pkg.sv
`default_nettype none
package amw_pkg;
  typedef enum logic [2:0] {
    AMW_IDLE   = 3'b000,
    AMW_SETUP  = 3'b001,
    AMW_STROBE = 3'b010,
    AMW_WAIT   = 3'b011,
    AMW_DONE   = 3'b100
  } amw_state_t;
  typedef enum logic [1:0] {
    AMW_TGT_ASYNC = 2'b00,
    AMW_TGT_SDRAM = 2'b01,
    AMW_TGT_REGS  = 2'b10
  } amw_target_t;
endpackage : amw_pkg
`default_nettype wire

// ### hw/amw_wait_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "amw_map.svh"
// wait counter control between the sequencer and the counter
interface amw_wait_if;
  logic start;
  logic count_en;
  logic [`AMW_CNT_W-1:0] limit;
  logic expired;
  modport seq (output start, output count_en, output limit, input expired);
  modport cnt (input start, input count_en, input limit, output expired);
endinterface : amw_wait_if
`default_nettype wire

// ### hw/amw_wait_cnt.sv
`timescale 1ns/1ps
`default_nettype none
`include "amw_map.svh"
module amw_wait_cnt
  import amw_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic reset_i,   // async reset, high
  amw_wait_if.cnt ctl         // counter control
);
  logic [`AMW_CNT_W-1:0] count;
  logic [`AMW_CNT_W-1:0] next_count;
  logic expired;
  logic next_expired;

  always_comb begin
    next_count = count;
    next_expired = expired;
    if (ctl.start) begin
      next_count = '0;
      next_expired = 1'b0;
    end else if (ctl.count_en && !expired) begin
      next_count = count + `AMW_ONE_CNT;
      if (count >= ctl.limit) begin
        next_expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign ctl.expired = expired;
endmodule : amw_wait_cnt
`default_nettype wire

// ### tb/amw_async_read_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "amw_map.svh"
module amw_async_read_props
  import amw_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic reset_i, // reset
  input wire logic req_i, // request
  input wire logic [1:0] req_target_i, // target
  input wire logic [`AMW_ADDR_W-1:0] req_addr_i, // address
  input wire logic [`AMW_CNT_W-1:0] max_wait_i, // limit
  input wire logic [`AMW_DATA_W-1:0] reg_rdata_i, // reg data
  input wire logic sdram_done_i, // sdram done
  input wire logic mem_wait_i, // wait pin
  input wire logic busy_o, // busy
  input wire logic ack_o, // ack
  input wire logic [`AMW_DATA_W-1:0] rdata_o, // data
  input wire logic timeout_o, // error
  input wire logic sdram_req_o, // sdram start
  input wire logic mem_cs_n_o, // select
  input wire logic [`AMW_ADDR_W-1:0] mem_a_o // address
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // raw wait count is an upper bound, the design sees wait two cycles late
  logic [8:0] wcnt;
  logic [8:0] next_wcnt;
  logic take;
  assign take = req_i && !busy_o;
  always_comb next_wcnt = mem_cs_n_o ? 9'h000 : wcnt + {8'h00, mem_wait_i};
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) wcnt <= 9'h000;
    else wcnt <= next_wcnt;
  end
  AST_TO_ZERO: assert property ($rose(timeout_o) |-> rdata_o == `AMW_ZERO_DATA)
    else $error("timed-out read data not zero");
  AST_TO_ACK: assert property ($rose(timeout_o) |=> ack_o)
    else $error("time-out not completed by ack");
  AST_TO_LIMIT: assert property ($rose(timeout_o) |-> wcnt >= {1'b0, max_wait_i} + 9'h001)
    else $error("time-out before limit");
  AST_TO_FALL: assert property ($fell(timeout_o) |=> ack_o && !busy_o)
    else $error("error cleared without completion");
  AST_REG_READ: assert property (take && req_target_i == AMW_TGT_REGS |=>
    busy_o ##1 ack_o && rdata_o == $past(reg_rdata_i) && timeout_o == $past(timeout_o, 2))
    else $error("register read wrong");
  AST_SD_START: assert property (take && req_target_i == AMW_TGT_SDRAM |=>
    sdram_req_o ##1 !sdram_req_o)
    else $error("sdram start pulse wrong");
  AST_SD_DONE: assert property (sdram_done_i && busy_o |=> !timeout_o ##1 ack_o)
    else $error("sdram completion wrong");
  AST_ASYNC_START: assert property (take && req_target_i == AMW_TGT_ASYNC |=>
    !mem_cs_n_o && mem_a_o == $past(req_addr_i) && wcnt == 9'h000)
    else $error("async access start wrong");
endmodule : amw_async_read_props
bind amw_async_read amw_async_read_props i_props (.clk_sys_i, .reset_i, .req_i, .req_target_i,
  .req_addr_i, .max_wait_i, .reg_rdata_i, .sdram_done_i, .mem_wait_i, .busy_o, .ack_o,
  .rdata_o, .timeout_o, .sdram_req_o, .mem_cs_n_o, .mem_a_o);
`default_nettype wire

// ### tb/amw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module amw_mem_model (
  input wire logic clk_sys_i, // clock
  input wire logic oe_n_i, // read strobe
  input wire logic [23:0] a_i, // address
  input wire logic hold_i, // never release wait
  input wire logic [7:0] wlen_i, // wait cycles
  output logic [31:0] d_o, // data
  output logic wait_o // wait
);
  logic [7:0] cnt;
  always_ff @(posedge clk_sys_i) cnt <= oe_n_i ? 8'h00 : cnt + {7'h00, cnt != 8'hff};
  assign wait_o = !oe_n_i && (hold_i || cnt < wlen_i);
  // released bus shows inverted pattern, not stale data
  assign d_o = oe_n_i ? ~{8'h5a, a_i} : {8'h5a, a_i};
endmodule : amw_mem_model
`default_nettype wire

// ### tb/amw_async_read_test.sv
`timescale 1ns/1ps
`default_nettype none
module amw_async_read_test;
  import amw_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i = 1'b0, sdram_done_i = 1'b0, hold = 1'b0, mem_wait_i, busy_o, ack_o, timeout_o;
  logic sdram_req_o, mem_cs_n_o, mem_oe_n_o;
  logic [1:0] req_target_i = 2'h0, req_cs_i = 2'h0, mem_cs_sel_o;
  logic [23:0] req_addr_i = 24'h0, mem_a_o;
  logic [3:0] ext_wait_en_i = 4'h1;
  logic [7:0] max_wait_i = 8'h03, wlen = 8'h02;
  logic [31:0] reg_rdata_i = 32'h0, mem_d_i, rdata_o;
  logic [2:0] sd_cnt = 3'h0;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  amw_async_read i_dut (.clk_sys_i, .reset_i, .req_i, .req_target_i, .req_cs_i, .req_addr_i,
    .ext_wait_en_i, .max_wait_i, .sdram_rdata_i(32'h5d5d_0001), .sdram_done_i, .reg_rdata_i,
    .mem_d_i, .mem_wait_i, .busy_o, .ack_o, .rdata_o, .timeout_o, .sdram_req_o, .mem_cs_n_o,
    .mem_cs_sel_o, .mem_oe_n_o, .mem_a_o);
  amw_mem_model i_mem (.clk_sys_i, .oe_n_i(mem_oe_n_o), .a_i(mem_a_o), .hold_i(hold),
    .wlen_i(wlen), .d_o(mem_d_i), .wait_o(mem_wait_i));
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // sdram answers four cycles after its start pulse
  always @(posedge clk_sys_i) begin
    sd_cnt <= sdram_req_o ? 3'h3 : sd_cnt - {2'h0, sd_cnt != 3'h0};
    sdram_done_i <= (sd_cnt == 3'h1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ack is read at the edge after it rose, so rdata and timeout stand
  task automatic acc(input logic [1:0] tg, input logic [1:0] cs, input logic [23:0] a);
    int n;
    n = 0;
    req_target_i <= tg;
    req_cs_i <= cs;
    req_addr_i <= a;
    req_i <= 1'b1;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    while (ack_o !== 1'b1 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("ack", {31'h0, ack_o}, 32'h1);
  endtask : acc
  task automatic t_clean();
    acc(AMW_TGT_ASYNC, 2'h0, 24'h000123);
    chk("rdata", rdata_o, 32'h5a00_0123);
    chk("timeout", {31'h0, timeout_o}, 32'h0);
  endtask : t_clean
  task automatic t_to_reg(input logic [31:0] rv);
    hold <= 1'b1;
    acc(AMW_TGT_ASYNC, 2'h0, 24'h000044);
    chk("rdata", rdata_o, 32'h0);
    chk("timeout", {31'h0, timeout_o}, 32'h1);
    hold <= 1'b0;
    reg_rdata_i <= rv;
    acc(AMW_TGT_REGS, 2'h0, 24'h000000);
    chk("reg rdata", rdata_o, rv);
    chk("timeout", {31'h0, timeout_o}, 32'h1);
  endtask : t_to_reg
  task automatic t_clr_other_cs();
    wlen <= 8'h0c;
    acc(AMW_TGT_ASYNC, 2'h1, 24'h000a0a);
    chk("rdata", rdata_o, 32'h5a00_0a0a);
    chk("cs sel", {30'h0, mem_cs_sel_o}, 32'h1);
    chk("timeout", {31'h0, timeout_o}, 32'h0);
  endtask : t_clr_other_cs
  task automatic t_clr_same_cs();
    ext_wait_en_i <= 4'h0;
    wlen <= 8'h06;
    acc(AMW_TGT_ASYNC, 2'h0, 24'h000b0b);
    chk("rdata", rdata_o, 32'h5a00_0b0b);
    chk("timeout", {31'h0, timeout_o}, 32'h0);
    ext_wait_en_i <= 4'h1;
  endtask : t_clr_same_cs
  task automatic t_clr_sdram();
    acc(AMW_TGT_SDRAM, 2'h0, 24'h000000);
    chk("sdram rdata", rdata_o, 32'h5d5d_0001);
    chk("timeout", {31'h0, timeout_o}, 32'h0);
  endtask : t_clr_sdram
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_clean();
    t_to_reg(32'hc0de_0001);
    t_clr_other_cs();
    t_to_reg(32'hc0de_0002);
    t_clr_same_cs();
    t_to_reg(32'hc0de_0003);
    t_clr_sdram();
    wrap_up();
  end
endmodule : amw_async_read_test
`default_nettype wire
